// ==== hdl/exception_stacking_unit.sv ====
// Exception entry sequencer: stacks status and return address, fetches the vector.
// Summary of operation
// - Leave return address at final stack pointer, status word just above it.
// - Delay-slot address error or slot-illegal stacks the preceding branch address.
// - Address error outside a slot stacks the faulting instruction address.
// - Interrupt stacks address following the last completed instruction.
// - Trap stacks address of the instruction after the trap.
// - Undefined opcode outside a slot stacks its own address.
// - Misaligned stack pointer raises an address error during stacking.
// - Misaligned vector base raises an address error during entry.
// - Such an error is handled only after the current entry completes.
// - Stacking for an address error ignores further address errors.
// - Stacking writes are issued even when misaligned.
// - Pointer drops by four per write; bus address has low bits cleared.
// - Load-to-status instruction in a delay slot is slot-illegal.
// - Maskable requests resolved over sixteen priority levels.
// - One non-maskable and eight maskable request inputs; only eight are masked.
// - Non-maskable always taken, others above mask; mask loaded, fifteen for it.
// - Push status then return address, fetch vector, branch without slot.
`timescale 1ns/1ps
`default_nettype none
module exception_stacking_unit (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Request pins
   input wire logic nmiPin,
   input wire logic [7:0] maskable_request_pins,
   input wire logic [31:0] irqLevels,
   // Pipeline exception request
   input wire logic excReq,
   input wire exc_stack_pkg::exc_kind_t excKind,
   input wire logic inDelaySlot,
   input wire logic [31:0] instrPc,
   input wire logic [31:0] branchPc,
   input wire logic [31:0] nextPc,
   input wire logic [7:0] trapVector,
   // Processor state
   input wire logic [31:0] status_word,
   input wire logic [31:0] stack_pointer_reg,
   input wire logic [31:0] vector_base,
   // Memory bus
   output logic busReq,
   output logic busWrite,
   output logic [31:0] busAddr,
   output logic [31:0] busWdata,
   input wire logic busAck,
   input wire logic [31:0] busRdata,
   // Results to the pipeline
   output logic busy,
   output logic entryDone,
   output logic intAccept,
   output logic [31:0] handlerPc,
   output logic [31:0] newSp,
   output logic [31:0] newStatus
);
   exc_stack_pkg::state_t state_r;
   logic [1:0] nmiSync_r;
   logic [15:0] irqSync_r;
   logic nmiPrev_r, nmiPend_r, faultPend_r, isAddrErr_r;
   logic [31:0] spCur_r, retPc_r, srCur_r;
   logic [7:0] vec_r;
   logic [3:0] bestLevel;
   logic [2:0] bestIndex;
   logic [31:0] spDown, retSel;
   logic [7:0] vecSel;
   logic excTake, intTake, startAny, spMis, vbrMis, slotIll;

   // Two flip-flop synchronisers on the request pins.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         nmiSync_r <= 2'h0;
         irqSync_r <= 16'h0000;
         nmiPrev_r <= 1'b0;
      end else begin
         nmiSync_r <= {nmiSync_r[0], nmiPin};
         irqSync_r <= {irqSync_r[7:0], maskable_request_pins};
         nmiPrev_r <= nmiSync_r[1];
      end
   end

   priority_resolver u_resolver (
      .reqActive(irqSync_r[15:8]),
      .reqLevels(irqLevels),
      .bestLevel(bestLevel),
      .bestIndex(bestIndex)
   );

   // Request selection: pipeline exceptions first, then the non-maskable, then the masked ones.
   assign slotIll = inDelaySlot && (excKind != exc_stack_pkg::EXC_ADDR);
   assign excTake = excReq && ((excKind != exc_stack_pkg::EXC_LDCSR) || inDelaySlot);
   assign intTake = !excTake && (nmiPend_r ||
                    (bestLevel > status_word[exc_stack_pkg::MASK_MSB:exc_stack_pkg::MASK_LSB]));
   assign startAny = (state_r == exc_stack_pkg::ST_IDLE) && (excTake || intTake);
   assign spDown = stack_pointer_reg - exc_stack_pkg::STACK_STEP;
   assign spMis = stack_pointer_reg[1:0] != exc_stack_pkg::ALIGN_MASK;
   assign vbrMis = vector_base[1:0] != exc_stack_pkg::ALIGN_MASK;

   // Return address and vector by cause.
   always_comb begin
      retSel = nextPc;
      vecSel = exc_stack_pkg::VEC_NMI;
      if (excTake) begin
         if (slotIll) begin
            retSel = branchPc;
            vecSel = exc_stack_pkg::VEC_SLOT_ILLEGAL;
         end else if (excKind == exc_stack_pkg::EXC_ADDR) begin
            retSel = inDelaySlot ? branchPc : instrPc;
            vecSel = exc_stack_pkg::VEC_ADDR_ERR;
         end else if (excKind == exc_stack_pkg::EXC_TRAP) begin
            retSel = nextPc;
            vecSel = trapVector;
         end else begin
            retSel = instrPc;
            vecSel = exc_stack_pkg::VEC_GEN_ILLEGAL;
         end
      end else if (!nmiPend_r) begin
         vecSel = exc_stack_pkg::VEC_IRQ_BASE + {5'h00, bestIndex};
      end
   end

   // Non-maskable edge capture, held until taken; a new edge wins over the clear.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         nmiPend_r <= 1'b0;
      end else if (nmiSync_r[1] && !nmiPrev_r) begin
         nmiPend_r <= 1'b1;
      end else if (startAny && !excTake) begin
         nmiPend_r <= 1'b0;
      end
   end

   // Entry sequencer with the stacking bus cycles.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_r <= exc_stack_pkg::ST_IDLE;
         busReq <= 1'b0;
         busWrite <= 1'b0;
         busAddr <= exc_stack_pkg::WORD_RESET;
         busWdata <= exc_stack_pkg::WORD_RESET;
         spCur_r <= exc_stack_pkg::WORD_RESET;
         retPc_r <= exc_stack_pkg::WORD_RESET;
         srCur_r <= exc_stack_pkg::WORD_RESET;
         vec_r <= 8'h00;
         isAddrErr_r <= 1'b0;
         faultPend_r <= 1'b0;
         busy <= 1'b0;
         entryDone <= 1'b0;
         intAccept <= 1'b0;
         handlerPc <= exc_stack_pkg::WORD_RESET;
      end else begin
         entryDone <= 1'b0;
         intAccept <= 1'b0;
         case (state_r)
            exc_stack_pkg::ST_IDLE: begin
               if (startAny) begin
                  state_r <= exc_stack_pkg::ST_PUSHS;
                  busy <= 1'b1;
                  busReq <= 1'b1;
                  busWrite <= 1'b1;
                  busAddr <= {spDown[31:2], 2'h0};
                  busWdata <= status_word;
                  spCur_r <= spDown;
                  srCur_r <= status_word;
                  retPc_r <= retSel;
                  vec_r <= vecSel;
                  intAccept <= intTake;
                  isAddrErr_r <= excTake && !slotIll && (excKind == exc_stack_pkg::EXC_ADDR);
                  faultPend_r <= spMis && !(excTake && !slotIll
                                 && (excKind == exc_stack_pkg::EXC_ADDR));
               end
            end
            exc_stack_pkg::ST_PUSHS: begin
               if (busAck) begin
                  state_r <= exc_stack_pkg::ST_PUSHR;
                  busAddr <= {spCur_r[31:2] - 30'h1, 2'h0};
                  busWdata <= retPc_r;
                  spCur_r <= spCur_r - exc_stack_pkg::STACK_STEP;
               end
            end
            exc_stack_pkg::ST_PUSHR: begin
               if (busAck) begin
                  state_r <= exc_stack_pkg::ST_FETCH;
                  busWrite <= 1'b0;
                  busAddr <= vector_base + {22'h0, vec_r, 2'h0};
                  if (vbrMis && !isAddrErr_r) begin
                     faultPend_r <= 1'b1;
                  end
               end
            end
            exc_stack_pkg::ST_FETCH: begin
               if (busAck) begin
                  state_r <= exc_stack_pkg::ST_DONE;
                  busReq <= 1'b0;
                  handlerPc <= busRdata;
               end
            end
            exc_stack_pkg::ST_DONE: begin
               if (faultPend_r) begin
                  // Deferred address error, stacked behind the finished entry.
                  state_r <= exc_stack_pkg::ST_PUSHS;
                  busReq <= 1'b1;
                  busWrite <= 1'b1;
                  busAddr <= {spCur_r[31:2] - 30'h1, 2'h0};
                  busWdata <= newStatus;
                  spCur_r <= spCur_r - exc_stack_pkg::STACK_STEP;
                  srCur_r <= newStatus;
                  retPc_r <= handlerPc;
                  vec_r <= exc_stack_pkg::VEC_ADDR_ERR;
                  isAddrErr_r <= 1'b1;
                  faultPend_r <= 1'b0;
               end else begin
                  state_r <= exc_stack_pkg::ST_IDLE;
                  busy <= 1'b0;
                  entryDone <= 1'b1;
               end
            end
            default: begin
               state_r <= exc_stack_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Updated status word: mask field takes the accepted level.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         newStatus <= exc_stack_pkg::WORD_RESET;
      end else if (startAny) begin
         newStatus <= status_word;
         if (intTake && nmiPend_r) begin
            newStatus[exc_stack_pkg::MASK_MSB:exc_stack_pkg::MASK_LSB] <=
               exc_stack_pkg::NMI_MASK_LEVEL;
         end else if (intTake) begin
            newStatus[exc_stack_pkg::MASK_MSB:exc_stack_pkg::MASK_LSB] <= bestLevel;
         end
      end
   end

   assign newSp = spCur_r;

   // Checks.
   push_order_a: assert property (@(posedge clk_sys) disable iff (reset)
      state_r == exc_stack_pkg::ST_PUSHS && busAck |=> state_r == exc_stack_pkg::ST_PUSHR)
      else $error("Status push not followed by return push.");
   ret_above_a: assert property (@(posedge clk_sys) disable iff (reset)
      state_r == exc_stack_pkg::ST_PUSHS && busAck |=> busAddr == $past(busAddr) - 32'h4)
      else $error("Return address not directly below status word.");
   align_addr_a: assert property (@(posedge clk_sys) disable iff (reset)
      busReq && busWrite |-> busAddr[1:0] == 2'h0)
      else $error("Stacking address not word aligned.");
   sp_step_a: assert property (@(posedge clk_sys) disable iff (reset)
      startAny |=> newSp == $past(stack_pointer_reg) - 32'h4)
      else $error("Pointer not lowered by four.");
   write_issued_a: assert property (@(posedge clk_sys) disable iff (reset)
      startAny && spMis |=> busReq && busWrite)
      else $error("Misaligned stacking write suppressed.");
   trap_ret_a: assert property (@(posedge clk_sys) disable iff (reset)
      startAny && excTake && excKind == exc_stack_pkg::EXC_TRAP && !inDelaySlot
      |=> retPc_r == $past(nextPc))
      else $error("Trap return address wrong.");
   slot_ret_a: assert property (@(posedge clk_sys) disable iff (reset)
      startAny && excTake && inDelaySlot |=> retPc_r == $past(branchPc))
      else $error("Slot exception return address wrong.");
   undef_ret_a: assert property (@(posedge clk_sys) disable iff (reset)
      startAny && excTake && excKind == exc_stack_pkg::EXC_UNDEF && !inDelaySlot
      |=> retPc_r == $past(instrPc) && vec_r == exc_stack_pkg::VEC_GEN_ILLEGAL)
      else $error("Undefined opcode entry wrong.");
   ldc_slot_a: assert property (@(posedge clk_sys) disable iff (reset)
      state_r == exc_stack_pkg::ST_IDLE && excReq && excKind == exc_stack_pkg::EXC_LDCSR
      && inDelaySlot |=> vec_r == exc_stack_pkg::VEC_SLOT_ILLEGAL)
      else $error("Load-to-status in slot not slot-illegal.");
   nmi_mask_a: assert property (@(posedge clk_sys) disable iff (reset)
      startAny && intTake && nmiPend_r |=> newStatus[7:4] == 4'hF)
      else $error("Non-maskable entry mask not fifteen.");
   no_nest_a: assert property (@(posedge clk_sys) disable iff (reset)
      isAddrErr_r && state_r != exc_stack_pkg::ST_DONE |-> !faultPend_r)
      else $error("Address error raised while stacking for one.");
   fault_after_a: assert property (@(posedge clk_sys) disable iff (reset)
      state_r == exc_stack_pkg::ST_DONE && faultPend_r |=> !entryDone && isAddrErr_r)
      else $error("Deferred address error not started.");
   vec_addr_a: assert property (@(posedge clk_sys) disable iff (reset)
      state_r == exc_stack_pkg::ST_PUSHR && busAck
      |=> busAddr == vector_base + {22'h0, vec_r, 2'h0})
      else $error("Vector fetch address wrong.");
   entry_c: cover property (@(posedge clk_sys) disable iff (reset)
      startAny ##[4:40] entryDone);
   nested_c: cover property (@(posedge clk_sys) disable iff (reset)
      state_r == exc_stack_pkg::ST_DONE && faultPend_r);
   irq_c: cover property (@(posedge clk_sys) disable iff (reset) intAccept && !nmiPend_r);
endmodule
`default_nettype wire

// ==== hdl/priority_resolver.sv ====
// Picks the highest priority maskable request among the eight sources.
`timescale 1ns/1ps
`default_nettype none
module priority_resolver (
   // Active request flags and per-source priorities
   input wire logic [exc_stack_pkg::NUM_IRQ-1:0] reqActive,
   input wire logic [exc_stack_pkg::NUM_IRQ*exc_stack_pkg::LVL_W-1:0] reqLevels,
   // Winner
   output logic [exc_stack_pkg::LVL_W-1:0] bestLevel,
   output logic [2:0] bestIndex
);
   logic [exc_stack_pkg::LVL_W-1:0] lvlChain [exc_stack_pkg::NUM_IRQ:0];
   logic [2:0] idxChain [exc_stack_pkg::NUM_IRQ:0];

   assign lvlChain[0] = exc_stack_pkg::LEVEL_RESET;
   assign idxChain[0] = 3'h0;
   // Each stage keeps the higher level; lower index wins a tie among the 16 levels.
   genvar g;
   generate
      for (g = 0; g < exc_stack_pkg::NUM_IRQ; g++) begin : g_stage
         logic [exc_stack_pkg::LVL_W-1:0] myLevel;
         assign myLevel = reqActive[g] ? reqLevels[g*exc_stack_pkg::LVL_W +: exc_stack_pkg::LVL_W]
                                       : exc_stack_pkg::LEVEL_RESET;
         assign lvlChain[g+1] = (myLevel > lvlChain[g]) ? myLevel : lvlChain[g];
         assign idxChain[g+1] = (myLevel > lvlChain[g]) ? 3'(g) : idxChain[g];
      end
   endgenerate
   assign bestLevel = lvlChain[exc_stack_pkg::NUM_IRQ];
   assign bestIndex = idxChain[exc_stack_pkg::NUM_IRQ];
endmodule
`default_nettype wire

// ==== pkg/exc_stack_pkg.sv ====
// Constants and types shared by the exception stacking unit.
package exc_stack_pkg;
   // Entry sequencer states, Gray coded from ST_IDLE to ST_DONE along the usual path.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_PUSHS = 3'h1,
      ST_PUSHR = 3'h3,
      ST_FETCH = 3'h2,
      ST_DONE  = 3'h6
   } state_t;
   // Exception causes reported by the pipeline.
   typedef enum logic [1:0] {
      EXC_ADDR  = 2'h0,
      EXC_UNDEF = 2'h1,
      EXC_TRAP  = 2'h2,
      EXC_LDCSR = 2'h3
   } exc_kind_t;
   localparam int unsigned NUM_IRQ = 8;
   localparam int unsigned LVL_W = 4;
   localparam logic [31:0] STACK_STEP = 32'h0000_0004;
   localparam logic [1:0] ALIGN_MASK = 2'h0;
   localparam logic [3:0] NMI_MASK_LEVEL = 4'hF;
   // Position of the priority mask field inside the status word.
   localparam int unsigned MASK_LSB = 4;
   localparam int unsigned MASK_MSB = 7;
   // Vector numbers; plain defaults.
   localparam logic [7:0] VEC_GEN_ILLEGAL = 8'h04;
   localparam logic [7:0] VEC_SLOT_ILLEGAL = 8'h06;
   localparam logic [7:0] VEC_ADDR_ERR = 8'h09;
   localparam logic [7:0] VEC_NMI = 8'h0B;
   localparam logic [7:0] VEC_IRQ_BASE = 8'h40;
   // Reset values.
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [3:0] LEVEL_RESET = 4'h0;
endpackage

// ==== testbench/mem_bus_model.sv ====
// Memory bus model: acknowledges each phase after a set stall and logs the traffic.
`timescale 1ns/1ps
`default_nettype none
module mem_bus_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Memory bus
   input wire logic busReq,
   input wire logic busWrite,
   input wire logic [31:0] busAddr,
   input wire logic [31:0] busWdata,
   output logic busAck,
   output logic [31:0] busRdata,
   // Stall in cycles before each acknowledge
   input wire logic [3:0] ackDelay
);
   logic [3:0] waitCnt;
   logic [31:0] wrAddr[$];
   logic [31:0] wrData[$];
   logic [31:0] rdAddr[$];
   // Acks one phase after the stall; read data is the address under a key.
   // Outside a read acknowledge the data lines toggle so stale values never look valid.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         busAck <= 1'b0;
         waitCnt <= 4'h0;
         busRdata <= 32'h0;
      end else if (busReq && !busAck && waitCnt == ackDelay) begin
         busAck <= 1'b1;
         waitCnt <= 4'h0;
         if (busWrite) begin
            wrAddr.push_back(busAddr);
            wrData.push_back(busWdata);
            busRdata <= ~busRdata;
         end else begin
            rdAddr.push_back(busAddr);
            busRdata <= busAddr ^ 32'h5A5A_0000;
         end
      end else begin
         busAck <= 1'b0;
         busRdata <= ~busRdata;
         if (busReq && !busAck) begin
            waitCnt <= waitCnt + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking testbench for the exception stacking unit.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_sys, reset, nmiPin, excReq, inDelaySlot, busReq, busWrite, busAck;
   logic busy, entryDone, intAccept;
   logic [7:0] maskable_request_pins, trapVector;
   logic [31:0] irqLevels, instrPc, branchPc, nextPc, status_word, stack_pointer_reg;
   logic [31:0] vector_base, busAddr, busWdata, busRdata, handlerPc, newSp, newStatus;
   exc_stack_pkg::exc_kind_t excKind;
   logic [3:0] ackDelay;
   int failures, n_checks, intCount;
   exception_stacking_unit u_dut (.clk_sys, .reset, .nmiPin, .maskable_request_pins,
      .irqLevels, .excReq, .excKind, .inDelaySlot, .instrPc, .branchPc, .nextPc,
      .trapVector, .status_word, .stack_pointer_reg, .vector_base, .busReq, .busWrite,
      .busAddr, .busWdata, .busAck, .busRdata, .busy, .entryDone, .intAccept,
      .handlerPc, .newSp, .newStatus);
   mem_bus_model u_mem (.clk_sys, .reset, .busReq, .busWrite, .busAddr, .busWdata,
      .busAck, .busRdata, .ackDelay);
   // Clock generation.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Counts interrupt acceptance pulses.
   always @(posedge clk_sys) begin
      if (intAccept === 1'b1) intCount++;
   end
   // Compares one value and reports a mismatch.
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Prints the verdict and ends the run.
   task automatic conclude();
      if (failures == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   function automatic logic [31:0] va(input logic [7:0] vec);
      return vector_base + {22'h0, vec, 2'h0};
   endfunction
   // Waits for acceptance, drops all requests, then waits for the end of entry.
   task automatic wait_done();
      int n;
      n = 0;
      while (busy !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      @(posedge clk_sys);
      excReq <= 1'b0;
      nmiPin <= 1'b0;
      maskable_request_pins <= 8'h00;
      n = 0;
      while (entryDone !== 1'b1 && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
      chk("entry end", {31'h0, entryDone}, 32'h1);
      @(posedge clk_sys);
   endtask
   // Starts one pipeline exception with a clean log.
   task automatic run_exc(input exc_stack_pkg::exc_kind_t k, input logic slot);
      u_mem.wrAddr.delete();
      u_mem.wrData.delete();
      u_mem.rdAddr.delete();
      @(posedge clk_sys);
      excKind <= k;
      inDelaySlot <= slot;
      excReq <= 1'b1;
      wait_done();
   endtask
   // Lets an interrupt already driven on the pins start an entry, with no pipeline request.
   task automatic run_int();
      u_mem.wrAddr.delete();
      u_mem.wrData.delete();
      u_mem.rdAddr.delete();
      wait_done();
   endtask
   // Judges one aligned two-word frame, the vector read and the results.
   task automatic chk_frame(input logic [31:0] ret, input logic [7:0] vec, input logic [31:0] st);
      logic [31:0] sp;
      sp = stack_pointer_reg;
      chk("writes", 32'(u_mem.wrAddr.size()), 32'h2);
      chk("status addr", u_mem.wrAddr[0], sp - 32'h4);
      chk("status data", u_mem.wrData[0], status_word);
      chk("return addr", u_mem.wrAddr[1], sp - 32'h8);
      chk("return data", u_mem.wrData[1], ret);
      chk("vector addr", u_mem.rdAddr[0], va(vec));
      chk("handler", handlerPc, va(vec) ^ 32'h5A5A_0000);
      chk("new sp", newSp, sp - 32'h8);
      chk("new status", newStatus, st);
   endtask
   // Holds a request that must be refused and checks that no entry starts.
   task automatic expect_idle(input string what);
      repeat (12) begin
         @(negedge clk_sys);
         chk(what, {31'h0, busy}, 32'h0);
      end
      @(posedge clk_sys);
      excReq <= 1'b0;
   endtask
   // Misaligned stack pointer: first entry ends, then one address error entry.
   task automatic misaligned_sp();
      stack_pointer_reg <= 32'h0000_1002;
      run_exc(exc_stack_pkg::EXC_TRAP, 1'b0);
      chk("writes", 32'(u_mem.wrAddr.size()), 32'h4);
      chk("wr0", u_mem.wrAddr[0], 32'h0000_0FFC);
      chk("wr1", u_mem.wrAddr[1], 32'h0000_0FF8);
      chk("wr2", u_mem.wrAddr[2], 32'h0000_0FF4);
      chk("wr3", u_mem.wrAddr[3], 32'h0000_0FF0);
      chk("vec2", u_mem.rdAddr[1], va(exc_stack_pkg::VEC_ADDR_ERR));
      chk("sp", newSp, 32'h0000_0FF2);
      chk("handler2", handlerPc, va(exc_stack_pkg::VEC_ADDR_ERR) ^ 32'h5A5A_0000);
      repeat (20) @(posedge clk_sys);
      chk("no loop", 32'(u_mem.wrAddr.size()), 32'h4);
      stack_pointer_reg <= 32'h0000_2000;
      vector_base <= 32'h0000_0102;
      run_exc(exc_stack_pkg::EXC_TRAP, 1'b0);
      chk("reads", 32'(u_mem.rdAddr.size()), 32'h2);
      vector_base <= 32'h0000_0100;
   endtask
   // Main sequence.
   initial begin
      reset = 1'b1;
      nmiPin = 1'b0;
      excReq = 1'b0;
      inDelaySlot = 1'b0;
      maskable_request_pins = 8'h00;
      trapVector = 8'h21;
      irqLevels = 32'h0000_5020;
      instrPc = 32'h0000_0400;
      branchPc = 32'h0000_03F0;
      nextPc = 32'h0000_0402;
      status_word = 32'h0000_0020;
      stack_pointer_reg = 32'h0000_2000;
      vector_base = 32'h0000_0100;
      excKind = exc_stack_pkg::EXC_TRAP;
      ackDelay = 4'h0;
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      run_exc(exc_stack_pkg::EXC_TRAP, 1'b0);
      chk_frame(nextPc, trapVector, status_word);
      run_exc(exc_stack_pkg::EXC_ADDR, 1'b1);
      chk_frame(branchPc, exc_stack_pkg::VEC_ADDR_ERR, status_word);
      run_exc(exc_stack_pkg::EXC_ADDR, 1'b0);
      chk_frame(instrPc, exc_stack_pkg::VEC_ADDR_ERR, status_word);
      ackDelay <= 4'h3;
      run_exc(exc_stack_pkg::EXC_UNDEF, 1'b0);
      chk_frame(instrPc, exc_stack_pkg::VEC_GEN_ILLEGAL, status_word);
      run_exc(exc_stack_pkg::EXC_UNDEF, 1'b1);
      chk_frame(branchPc, exc_stack_pkg::VEC_SLOT_ILLEGAL, status_word);
      run_exc(exc_stack_pkg::EXC_LDCSR, 1'b1);
      chk_frame(branchPc, exc_stack_pkg::VEC_SLOT_ILLEGAL, status_word);
      @(posedge clk_sys);
      excKind <= exc_stack_pkg::EXC_LDCSR;
      inDelaySlot <= 1'b0;
      excReq <= 1'b1;
      expect_idle("ldc outside slot");
      maskable_request_pins <= 8'h02;
      expect_idle("level at mask");
      maskable_request_pins <= 8'h08;
      run_int();
      chk_frame(nextPc, 8'h43, 32'h0000_0050);
      chk("int accept", 32'(intCount), 32'h1);
      status_word <= 32'h0000_00F0;
      nmiPin <= 1'b1;
      run_int();
      chk_frame(nextPc, exc_stack_pkg::VEC_NMI, 32'h0000_00F0);
      chk("nmi accept", 32'(intCount), 32'h2);
      status_word <= 32'h0000_0020;
      misaligned_sp();
      conclude();
   end
   // Watchdog against a hang.
   initial begin
      #(8 * 5000);
      failures++;
      conclude();
   end
endmodule
`default_nettype wire
